// File: design/rgtc_ramp_ctrl.v
// Digital timing control of a ramp generator with AHB-Lite register access.
// Assumes one 50 MHz clock; trigger inputs come from other clock domains.
`timescale 1ns/1ps
`include "rgtc_regs.vh"

// Overview of operation
// - Alternating mode: rise trigger makes ramp rise, fall trigger makes it fall.
// - Slope and rising modes: fall trigger discharges, rise trigger starts new ramp.
// - Fall trigger wins when both triggers are asserted together.
// - Each trigger is independently level or edge sensitive.
// - Two separate configuration bits select edge or level per trigger.
// - Level trigger held through one-shot is acted on when it ends.
// - Edges seen during the one-shot are discarded for good.
// - Edge-mode rise trigger acts only on its rising edge.
// - One-shot gives minimum discharge or minimum ramp segment time.
// - One-shot timer starts only while its enable bit is set.
// - In slope and rising modes the one-shot holds discharge closed and overrides rise trigger.
// - Enabled with run clear keeps discharge closed; run rising starts one-shot.
// - Operation continues unchanged while the system sleeps.
// - Any reset returns the logic to disabled.
module rgtc_ramp_ctrl #(
    parameter ONE_SHOT_CYCLES = `RGTC_ONE_SHOT_CYC
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Timing inputs and analog status
    input wire rise_trigger,
    input wire fall_trigger,
    input wire analog_ready,
    input wire sleep,
    // Ramp switch controls
    output reg ramp_enable,
    output reg ramp_rising,
    output reg discharge_close
);

    // ****************************************
    // Register file
    // ****************************************
    reg [31:0] ramp_control_first_reg;
    reg [31:0] ramp_control_second_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    wire addr_ok;
    wire [31:0] status_word;
    wire enable_bit;
    wire go_bit;
    wire one_shot_enable;
    wire [1:0] mode;
    wire rise_trigger_edge_select;
    wire fall_trigger_edge_select;

    assign enable_bit = ramp_control_first_reg[`RGTC_C0_EN];
    assign go_bit = ramp_control_first_reg[`RGTC_C0_GO];
    assign one_shot_enable = ramp_control_first_reg[`RGTC_C0_ONE_SHOT];
    assign mode = ramp_control_first_reg[`RGTC_C0_MODE_HI:`RGTC_C0_MODE_LO];
    assign rise_trigger_edge_select = ramp_control_second_reg[`RGTC_C1_RISE_EDGE_SEL];
    assign fall_trigger_edge_select = ramp_control_second_reg[`RGTC_C1_FALL_EDGE_SEL];

    function [31:0] read_mux;
        input [7:0] a;
        input [31:0] c0;
        input [31:0] c1;
        input [31:0] st;
        begin
            case (a)
                `RGTC_CTRL0_OFS: read_mux = c0;
                `RGTC_CTRL1_OFS: read_mux = c1;
                `RGTC_STAT_OFS: read_mux = st;
                default: read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    assign addr_ok = hsel && hready && htrans[1];

    // Writes land one cycle after the address phase; unmapped offsets are ignored.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ramp_control_first_reg <= `RGTC_CTRL0_RST;
            ramp_control_second_reg <= `RGTC_CTRL1_RST;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
            if (wr_pend_reg) begin
                if (wr_addr_reg == `RGTC_CTRL0_OFS) begin
                    ramp_control_first_reg <= {26'h0, hwdata[5:4], 1'b0, hwdata[2:0]};
                end
                if (wr_addr_reg == `RGTC_CTRL1_OFS) begin
                    ramp_control_second_reg <= {30'h0, hwdata[1:0]};
                end
            end
            if (addr_ok && !hwrite) begin
                hrdata <= read_mux(haddr, ramp_control_first_reg,
                    ramp_control_second_reg, status_word);
            end
        end
    end

    // ****************************************
    // Trigger synchronisers and edge detect
    // ****************************************
    reg [1:0] rise_sync_reg;
    reg [1:0] fall_sync_reg;
    reg rise_prev_reg;
    reg fall_prev_reg;
    reg [1:0] rdy_sync_reg;
    wire rise_level;
    wire fall_level;
    wire rise_edge;
    wire fall_edge;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_sync_reg <= 2'h0;
            fall_sync_reg <= 2'h0;
            rdy_sync_reg <= 2'h0;
            rise_prev_reg <= 1'b0;
            fall_prev_reg <= 1'b0;
        end else begin
            rise_sync_reg <= {rise_sync_reg[0], rise_trigger};
            fall_sync_reg <= {fall_sync_reg[0], fall_trigger};
            rdy_sync_reg <= {rdy_sync_reg[0], analog_ready};
            rise_prev_reg <= rise_sync_reg[1];
            fall_prev_reg <= fall_sync_reg[1];
        end
    end

    assign rise_level = rise_sync_reg[1];
    assign fall_level = fall_sync_reg[1];
    assign rise_edge = rise_sync_reg[1] && !rise_prev_reg;
    assign fall_edge = fall_sync_reg[1] && !fall_prev_reg;

    // ****************************************
    // One-shot and ramp state
    // ****************************************
    localparam [2:0] ST_OFF = 3'h1;
    localparam [2:0] ST_RISE = 3'h2;
    localparam [2:0] ST_FALL = 3'h4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [15:0] pulse_cnt_reg;
    reg [15:0] pulse_cnt_next;
    reg go_prev_reg;
    reg rise_ev;
    reg fall_ev;
    wire pulse_active;
    wire alt_mode;
    wire go_start;
    wire hold_shut;

    assign pulse_active = pulse_cnt_reg != 16'h0000;
    assign alt_mode = mode == `RGTC_MODE_ALT;
    assign go_start = enable_bit && go_bit && !go_prev_reg;
    assign hold_shut = (pulse_cnt_next != 16'h0000) && !alt_mode;

    // The sleep input is intentionally not used: the ramp keeps running in sleep.
    always @* begin
        // Edges during the one-shot are dropped; levels simply wait it out.
        rise_ev = !pulse_active && (rise_trigger_edge_select ? rise_edge : rise_level);
        fall_ev = !pulse_active && (fall_trigger_edge_select ? fall_edge : fall_level);
        state_next = state_reg;
        pulse_cnt_next = pulse_active ? pulse_cnt_reg - 16'h0001 : 16'h0000;
        case (state_reg)
            ST_OFF: begin
                if (enable_bit && go_bit) begin
                    state_next = alt_mode ? ST_FALL : ST_RISE;
                end
            end
            ST_RISE, ST_FALL: begin
                if (fall_ev) begin
                    if (state_reg != ST_FALL && one_shot_enable) begin
                        pulse_cnt_next = ONE_SHOT_CYCLES[15:0];
                    end
                    state_next = ST_FALL;
                end else if (rise_ev) begin
                    if (state_reg != ST_RISE && alt_mode && one_shot_enable) begin
                        pulse_cnt_next = ONE_SHOT_CYCLES[15:0];
                    end
                    state_next = ST_RISE;
                end
            end
            default: state_next = ST_OFF;
        endcase
        if (go_start && one_shot_enable) begin
            pulse_cnt_next = ONE_SHOT_CYCLES[15:0];
        end
        if (!(enable_bit && go_bit)) begin
            state_next = ST_OFF;
            pulse_cnt_next = 16'h0000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_OFF;
            pulse_cnt_reg <= 16'h0000;
            go_prev_reg <= 1'b0;
            ramp_enable <= 1'b0;
            ramp_rising <= 1'b0;
            discharge_close <= 1'b0;
        end else begin
            state_reg <= state_next;
            pulse_cnt_reg <= pulse_cnt_next;
            go_prev_reg <= enable_bit && go_bit;
            ramp_enable <= enable_bit;
            // A shut switch and a rising ramp would fight, so the one-shot masks rising.
            ramp_rising <= (state_next == ST_RISE) && !hold_shut;
            // Closed while enabled but not running, and in the discharging modes during the one-shot
            // and after a fall.
            discharge_close <= enable_bit && ((state_next == ST_OFF) ||
                hold_shut ||
                (!alt_mode && state_next == ST_FALL));
        end
    end

    assign status_word = {28'h0, rdy_sync_reg[1], pulse_active, discharge_close, ramp_rising};

endmodule

// File: design/rgtc_regs.vh
// Register offsets, field positions, reset values and timing counts of the ramp timing control.
// Included by the ramp timing control design file; definitions only.
`ifndef RGTC_REGS_VH
`define RGTC_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RGTC_CTRL0_OFS 8'h00
`define RGTC_CTRL1_OFS 8'h04
`define RGTC_STAT_OFS 8'h08

// ****************************************
// First control register fields
// ****************************************
`define RGTC_C0_EN 0
`define RGTC_C0_GO 1
`define RGTC_C0_ONE_SHOT 2
`define RGTC_C0_MODE_LO 4
`define RGTC_C0_MODE_HI 5
`define RGTC_CTRL0_RST 32'h0000_0000

// ****************************************
// Second control register fields
// ****************************************
`define RGTC_C1_RISE_EDGE_SEL 0
`define RGTC_C1_FALL_EDGE_SEL 1
`define RGTC_CTRL1_RST 32'h0000_0000

// ****************************************
// Status register fields
// ****************************************
`define RGTC_ST_RISING 0
`define RGTC_ST_DISCH 1
`define RGTC_ST_ONE_SHOT 2
`define RGTC_ST_RDY 3

// ****************************************
// Mode encodings
// ****************************************
`define RGTC_MODE_SLOPE 2'h0
`define RGTC_MODE_RISE 2'h1
`define RGTC_MODE_ALT 2'h2

// ****************************************
// Timing
// ****************************************
`define RGTC_CLK_MHZ 50
`define RGTC_ONE_SHOT_NS 50
`define RGTC_ONE_SHOT_CYC ((`RGTC_ONE_SHOT_NS * `RGTC_CLK_MHZ + 999) / 1000)

`endif

// File: verif/rgtc_ramp_ctrl_properties.sv
// Checker for the ramp timing control, bound to its top module.
// Assumes zero-wait single-word writes that land at the end of the data phase.
`timescale 1ns/1ps
module rgtc_ramp_ctrl_properties #(
    parameter ONE_SHOT_CYCLES = 3
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    // Triggers and switches
    input wire rise_trigger,
    input wire fall_trigger,
    input wire ramp_enable,
    input wire ramp_rising,
    input wire discharge_close
);
    // ****
    // Register shadow
    // ****
    // The shadow changes on the same edge as the block's own registers.
    reg w_reg;
    reg [7:0] a_reg;
    reg [5:0] c0_reg;
    reg [1:0] c1_reg;
    wire en = c0_reg[0];
    wire run = c0_reg[1:0] == 2'h3;
    wire alt = c0_reg[5:4] == 2'h2;
    wire fall_lvl = run && !c1_reg[1] && fall_trigger;
    wire rise_lvl = run && !c1_reg[0] && rise_trigger && !fall_trigger;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_reg <= 1'b0;
            a_reg <= 8'h00;
            c0_reg <= 6'h00;
            c1_reg <= 2'h0;
        end else begin
            w_reg <= hsel && htrans[1] && hwrite && hready;
            a_reg <= haddr;
            if (w_reg && a_reg == 8'h00) c0_reg <= hwdata[5:0];
            if (w_reg && a_reg == 8'h04) c1_reg <= hwdata[1:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Twelve cycles cover synchroniser, one-shot and output register delays.
    sequence fall_held;
        fall_lvl[*8] ##1 (fall_lvl && $stable(c0_reg))[*4];
    endsequence
    sequence rise_held;
        rise_lvl[*8] ##1 (rise_lvl && $stable(c0_reg))[*4];
    endsequence
    sequence leave_rise;
        ramp_rising ##1 (discharge_close && run && c0_reg[2] && !alt);
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer wrong");
    a_reset_off: assert property ($rose(hresetn)
        |-> !ramp_enable && !ramp_rising && !discharge_close) else $error("not idle");
    a_rise_open: assert property (ramp_rising
        |-> ramp_enable && !discharge_close) else $error("rising with switch shut");
    a_disch_en: assert property (discharge_close |-> ramp_enable)
        else $error("switch shut while disabled");
    a_stop_shut: assert property ((en && !c0_reg[1])[*3]
        |-> discharge_close && !ramp_rising) else $error("switch open while stopped");
    a_off_idle: assert property ((!en)[*3]
        |-> !ramp_enable && !discharge_close && !ramp_rising) else $error("active while off");
    a_fall_wins: assert property (fall_held
        |-> !ramp_rising && (alt || discharge_close)) else $error("fall level not obeyed");
    a_rise_level: assert property (rise_held |-> ramp_rising)
        else $error("rise level not obeyed");
    a_os_hold: assert property (leave_rise |-> discharge_close[*3])
        else $error("discharge shorter than one-shot");
endmodule

// File: verif/rgtc_ramp_ctrl_test.sv
// Self-checking bench for the ramp timing control.
// Sole bus master; trigger levels pass through the timing source model.
`timescale 1ns/1ps
module rgtc_ramp_ctrl_test;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep = 1'b0;
    logic rise_lvl = 1'b0, fall_lvl = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, q;
    wire [31:0] hrdata;
    wire hreadyout, hresp, rise_trigger, fall_trigger, ramp_enable, ramp_rising, discharge_close;
    int n_fail = 0, checks = 0, cyc = 0;
    // ****
    // Rows: ctrl0, ctrl1, {rise, fall} levels, {enable, rising, discharge}
    // ****
    logic [19:0] rw, rows [0:11] = '{20'h00000, 20'h01005, 20'h03026, 20'h03035, 20'h13026,
        20'h13015, 20'h23026, 20'h23034, 20'h23124, 20'h23104, 20'h23126, 20'h27314};
    rgtc_ramp_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rise_trigger(rise_trigger),
        .fall_trigger(fall_trigger), .analog_ready(1'b1), .sleep(sleep),
        .ramp_enable(ramp_enable), .ramp_rising(ramp_rising), .discharge_close(discharge_close));
    rgtc_timing_src SRC (.rise_lvl(rise_lvl), .fall_lvl(fall_lvl),
        .rise_trigger(rise_trigger), .fall_trigger(fall_trigger));
    initial forever #10 hclk = ~hclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic results;
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        tick(8);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            rw = rows[i];
            sleep <= i[0];
            bus(1'b1, 8'h04, {28'h0, rw[11:8]});
            bus(1'b1, 8'h00, {24'h0, rw[19:12]});
            {rise_lvl, fall_lvl} <= rw[5:4];
            tick(12);
            chk({29'h0, ramp_enable, ramp_rising, discharge_close}, {29'h0, rw[2:0]});
            bus(1'b0, 8'h08, 32'h0);
            chk(q, {28'h0, 2'h2, rw[0], rw[1]});
        end
        // An edge arriving two cycles after a fall reversal lands inside the one-shot.
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 8'h00, (k == 0) ? 32'h3 : 32'h7);
            bus(1'b1, 8'h04, 32'h0);
            {rise_lvl, fall_lvl} <= 2'h2;
            tick(12);
            bus(1'b1, 8'h04, (k == 2) ? 32'h2 : 32'h3);
            rise_lvl <= 1'b0;
            tick(12);
            fall_lvl <= 1'b1;
            tick(2);
            rise_lvl <= 1'b1;
            tick(12);
            chk({30'h0, ramp_rising, discharge_close}, (k == 1) ? 32'h1 : 32'h2);
        end
        bus(1'b1, 8'h00, 32'hffff_ffff);
        bus(1'b1, 8'h04, 32'hffff_ffff);
        bus(1'b1, 8'h0c, 32'hffff_ffff);
        bus(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0000_0037);
        bus(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0000_0003);
        bus(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h0);
        hresetn <= 1'b0;
        tick(2);
        chk({28'h0, hreadyout, ramp_enable, ramp_rising, discharge_close}, 32'h8);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0);
        results();
    end
endmodule
bind rgtc_ramp_ctrl rgtc_ramp_ctrl_properties #(.ONE_SHOT_CYCLES(ONE_SHOT_CYCLES)) u_props (
    .hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .rise_trigger(rise_trigger), .fall_trigger(fall_trigger), .ramp_enable(ramp_enable),
    .ramp_rising(ramp_rising), .discharge_close(discharge_close));

// File: verif/rgtc_timing_src.sv
// Timing sources for the ramp control: a rise source and a fall source.
// Levels come from the bench; lines move a few ns off the clock grid.
`timescale 1ns/1ps
module rgtc_timing_src #(
    parameter DLY = 3
) (
    // Levels asked for
    input wire rise_lvl,
    input wire fall_lvl,
    // Trigger lines
    output wire rise_trigger,
    output wire fall_trigger
);
    assign #DLY rise_trigger = rise_lvl;
    assign #DLY fall_trigger = fall_lvl;
endmodule
